/* include/tgc_pkg.sv */
// Operation
// [RULE_01] gate enable makes counting follow gate
// [RULE_02] polarity bit picks active gate level
// [RULE_03] toggle mode bit; clearing clears toggle ff
// [RULE_04] toggle ff flips on rising gate edge
// [RULE_05] single pulse mode bit enables pulse gating
// [RULE_06] bit 3 is go request and done status
// [RULE_07] unimplemented control bits read as zero
// [RULE_08] count only when on and gate qualified
`default_nettype none
package tgc_pkg;
    // byte addresses on the register bus
    localparam logic [3:0] TGC_OFF_GCON = 4'h0;
    localparam logic [3:0] TGC_OFF_CTRL = 4'h4;
    localparam logic [3:0] TGC_OFF_COUNT = 4'h8;
    // gate control and timer control field positions
    localparam int TGC_B_GE = 7;
    localparam int TGC_B_POL = 6;
    localparam int TGC_B_TM = 5;
    localparam int TGC_B_SPM = 4;
    localparam int TGC_B_GO = 3;
    localparam int TGC_B_SS1 = 1;
    localparam int TGC_B_SS0 = 0;
    localparam int TGC_B_ON = 0;
    // values after reset
    localparam logic [15:0] TGC_COUNT_RST = 16'h0000;
    localparam logic [31:0] TGC_RDATA_RST = 32'h0000_0000;

    typedef struct packed {
        logic gate_en;
        logic pol;
        logic tgl;
        logic spm;
        logic go;
        logic [1:0] src;
    } tgc_cfg_t;

    typedef enum logic [1:0] {
        TGC_SP_IDLE = 2'b00,
        TGC_SP_ARMED = 2'b01,
        TGC_SP_RUN = 2'b10
    } tgc_sp_t;

    typedef struct packed {
        logic meta;
        logic sync;
    } tgc_sync_st_t;

    typedef struct packed {
        logic prev;
        logic qprev;
        logic tgl_ff;
        tgc_sp_t sp;
    } tgc_qual_st_t;

    typedef struct packed {
        tgc_cfg_t cfg;
        logic on;
        logic [15:0] count;
        logic ack;
        logic [31:0] rdata;
    } tgc_top_st_t;
endpackage
`default_nettype wire

/* src/tgc_gate_qual.sv */
`default_nettype none
module tgc_gate_qual (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // configuration and selected gate
    input wire tgc_pkg::tgc_cfg_t i_cfg,
    input wire logic i_gate,
    // qualified gate and end of single pulse
    output logic o_gate_ok,
    output logic o_done
);
    import tgc_pkg::*;

    tgc_qual_st_t s_r;
    tgc_qual_st_t s_nxt;
    logic act;
    logic rise;
    logic q;

    // polarity, toggle and single pulse in one pass
    always_comb begin
        s_nxt = s_r;
        o_done = 1'b0;
        act = (i_gate == i_cfg.pol); // RULE_02
        rise = act & ~s_r.prev;
        s_nxt.prev = act;
        if (!i_cfg.tgl) begin
            s_nxt.tgl_ff = 1'b0; // RULE_03
        end else if (rise) begin
            s_nxt.tgl_ff = ~s_r.tgl_ff; // RULE_04
        end
        q = i_cfg.tgl ? s_r.tgl_ff : act; // RULE_04
        s_nxt.qprev = q;
        // pulse needs a fresh rising edge after go, so a gate already high waits
        case (s_r.sp)
            TGC_SP_IDLE: begin
                if (i_cfg.spm && i_cfg.go) begin
                    s_nxt.sp = TGC_SP_ARMED; // RULE_05
                end
            end
            TGC_SP_ARMED: begin
                if (!i_cfg.spm || !i_cfg.go) begin
                    s_nxt.sp = TGC_SP_IDLE;
                end else if (q && !s_r.qprev) begin
                    s_nxt.sp = TGC_SP_RUN;
                end
            end
            TGC_SP_RUN: begin
                if (!i_cfg.spm) begin
                    s_nxt.sp = TGC_SP_IDLE;
                end else if (!q) begin
                    s_nxt.sp = TGC_SP_IDLE;
                    o_done = 1'b1; // RULE_06
                end
            end
            default: begin
                s_nxt.sp = TGC_SP_IDLE;
            end
        endcase
        o_gate_ok = i_cfg.spm ? ((s_r.sp == TGC_SP_RUN) & q) : q; // RULE_05
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    property p_pol_level;
        @(posedge i_core_clk) disable iff (i_rst)
        (!i_cfg.tgl && !i_cfg.spm) |-> (o_gate_ok == (i_gate == i_cfg.pol));
    endproperty
    a_pol_level: assert property (p_pol_level) else $error("gate level not per polarity"); // RULE_02

    property p_tgl_clear;
        @(posedge i_core_clk) disable iff (i_rst)
        !i_cfg.tgl |=> !s_r.tgl_ff;
    endproperty
    a_tgl_clear: assert property (p_tgl_clear) else $error("toggle ff not cleared"); // RULE_03

    property p_tgl_flip;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_cfg.tgl && act && !s_r.prev) |=> (s_r.tgl_ff != $past(s_r.tgl_ff));
    endproperty
    a_tgl_flip: assert property (p_tgl_flip) else $error("toggle ff missed an edge"); // RULE_04

    sequence s_armed_edge;
        (s_r.sp == TGC_SP_ARMED) && i_cfg.spm && i_cfg.go && q && !s_r.qprev;
    endsequence
    property p_sp_start;
        @(posedge i_core_clk) disable iff (i_rst)
        s_armed_edge |=> (s_r.sp == TGC_SP_RUN);
    endproperty
    a_sp_start: assert property (p_sp_start) else $error("single pulse did not start"); // RULE_05
endmodule
`default_nettype wire

/* src/tgc_sync2.sv */
`default_nettype none
module tgc_sync2 (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // asynchronous level in, synchronised level out
    input wire logic i_async,
    output logic o_sync
);
    import tgc_pkg::*;

    tgc_sync_st_t s_r;
    tgc_sync_st_t s_nxt;

    // first stage feeds only the second
    always_comb begin
        s_nxt.meta = i_async;
        s_nxt.sync = s_r.meta;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_sync = s_r.sync;
endmodule
`default_nettype wire

/* src/tgc_timer_gate.sv */
// Local design decisions: the register offsets and register access over Avalon-MM.
`default_nettype none
module tgc_timer_gate (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // avalon-mm slave
    input wire logic [3:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [3:0] i_byteenable,
    input wire logic [31:0] i_writedata,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    // gate sources
    input wire logic i_gate_pin,
    input wire logic [2:0] i_gate_int,
    // timer state
    output logic [15:0] o_count,
    output logic o_count_en
);
    import tgc_pkg::*;

    tgc_top_st_t s_r;
    tgc_top_st_t s_nxt;
    logic pin_sync;
    logic gate_sel;
    logic gate_ok;
    logic sp_done;
    logic req;
    logic take;
    logic wr_gcon;
    logic wr_ctrl;
    logic wr_cnt;
    logic adv;

    // address match for one register
    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        hit = (a == off);
    endfunction

    // readback of the gate control byte, unused bit 2 stays zero
    function automatic logic [7:0] gcon_pack(input tgc_cfg_t c);
        logic [7:0] v;
        v = 8'h00;
        v[TGC_B_GE] = c.gate_en;
        v[TGC_B_POL] = c.pol;
        v[TGC_B_TM] = c.tgl;
        v[TGC_B_SPM] = c.spm;
        v[TGC_B_GO] = c.go;
        v[TGC_B_SS1] = c.src[1];
        v[TGC_B_SS0] = c.src[0];
        gcon_pack = v;
    endfunction

    // the pin is asynchronous, so it is synchronised before any use
    tgc_sync2 u_sync (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_async(i_gate_pin),
        .o_sync(pin_sync)
    );

    // source select: 0 is the pin, 1..3 internal sources
    always_comb begin
        case (s_r.cfg.src)
            2'h0: gate_sel = pin_sync;
            2'h1: gate_sel = i_gate_int[0];
            2'h2: gate_sel = i_gate_int[1];
            2'h3: gate_sel = i_gate_int[2];
            default: gate_sel = 1'b0;
        endcase
    end

    tgc_gate_qual u_qual (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_cfg(s_r.cfg),
        .i_gate(gate_sel),
        .o_gate_ok(gate_ok),
        .o_done(sp_done)
    );

    // one wait cycle per access keeps read data registered
    assign req = i_read | i_write;
    assign take = req & s_r.ack;
    assign o_waitrequest = req & ~s_r.ack;
    assign wr_gcon = take & i_write & i_byteenable[0] & hit(i_address, TGC_OFF_GCON);
    assign wr_ctrl = take & i_write & i_byteenable[0] & hit(i_address, TGC_OFF_CTRL);
    assign wr_cnt = take & i_write & (|i_byteenable[1:0]) & hit(i_address, TGC_OFF_COUNT);

    // gate enable is ignored while the timer is off
    assign adv = s_r.on & (~s_r.cfg.gate_en | gate_ok); // RULE_01 RULE_08

    // next state: bus, registers, counter
    always_comb begin
        s_nxt = s_r;
        s_nxt.ack = req & ~s_r.ack;
        if (req && !s_r.ack) begin
            s_nxt.rdata = 32'h0000_0000; // RULE_07
            if (hit(i_address, TGC_OFF_GCON)) begin
                s_nxt.rdata[7:0] = gcon_pack(s_r.cfg); // RULE_06 RULE_07
            end else if (hit(i_address, TGC_OFF_CTRL)) begin
                s_nxt.rdata[TGC_B_ON] = s_r.on;
            end else if (hit(i_address, TGC_OFF_COUNT)) begin
                s_nxt.rdata[15:0] = s_r.count;
            end
        end
        // hardware done clears go; a software write in the same cycle wins
        if (sp_done) begin
            s_nxt.cfg.go = 1'b0; // RULE_06
        end
        if (wr_gcon) begin
            s_nxt.cfg.gate_en = i_writedata[TGC_B_GE]; // RULE_01
            s_nxt.cfg.pol = i_writedata[TGC_B_POL]; // RULE_02
            s_nxt.cfg.tgl = i_writedata[TGC_B_TM]; // RULE_03
            s_nxt.cfg.spm = i_writedata[TGC_B_SPM]; // RULE_05
            s_nxt.cfg.go = i_writedata[TGC_B_GO]; // RULE_06
            s_nxt.cfg.src = {i_writedata[TGC_B_SS1], i_writedata[TGC_B_SS0]};
        end
        // go only means something inside single pulse mode
        if (!s_nxt.cfg.spm) begin
            s_nxt.cfg.go = 1'b0;
        end
        if (wr_ctrl) begin
            s_nxt.on = i_writedata[TGC_B_ON];
        end
        if (wr_cnt) begin
            if (i_byteenable[0]) begin
                s_nxt.count[7:0] = i_writedata[7:0];
            end
            if (i_byteenable[1]) begin
                s_nxt.count[15:8] = i_writedata[15:8];
            end
        end else if (adv) begin
            s_nxt.count = s_r.count + 16'h0001; // RULE_08
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            s_r.cfg <= '0;
            s_r.on <= 1'b0;
            s_r.count <= TGC_COUNT_RST;
            s_r.ack <= 1'b0;
            s_r.rdata <= TGC_RDATA_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_readdata = s_r.rdata;
    assign o_count = s_r.count;
    assign o_count_en = adv;

    property p_off_hold;
        @(posedge i_core_clk) disable iff (i_rst)
        (!s_r.on && !wr_cnt) |=> $stable(s_r.count);
    endproperty
    a_off_hold: assert property (p_off_hold) else $error("count moved while off"); // RULE_08

    property p_free_run;
        @(posedge i_core_clk) disable iff (i_rst)
        (s_r.on && !s_r.cfg.gate_en && !wr_cnt) |=> (s_r.count == $past(s_r.count) + 16'h0001);
    endproperty
    a_free_run: assert property (p_free_run) else $error("ungated count did not step"); // RULE_01

    property p_gated_hold;
        @(posedge i_core_clk) disable iff (i_rst)
        (s_r.on && s_r.cfg.gate_en && !gate_ok && !wr_cnt) |=> $stable(s_r.count);
    endproperty
    a_gated_hold: assert property (p_gated_hold) else $error("count moved with gate closed"); // RULE_01

    property p_gcon_zero;
        @(posedge i_core_clk) disable iff (i_rst)
        (take && i_read && hit(i_address, TGC_OFF_GCON)) |->
            (o_readdata[31:8] == 24'h000000 && o_readdata[2] == 1'b0);
    endproperty
    a_gcon_zero: assert property (p_gcon_zero) else $error("unused bits read nonzero"); // RULE_07

    property p_done_clears;
        @(posedge i_core_clk) disable iff (i_rst)
        (sp_done && !wr_gcon) |=> !s_r.cfg.go;
    endproperty
    a_done_clears: assert property (p_done_clears) else $error("go not cleared at done"); // RULE_06

    property p_one_wait;
        @(posedge i_core_clk) disable iff (i_rst)
        (req && o_waitrequest) |=> (!o_waitrequest);
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("waitrequest held too long");

    // bus timing: one wait state, writes land only on the taking edge
    property p_wait_idle;
        @(posedge i_core_clk) disable iff (i_rst)
        !req |-> !o_waitrequest;
    endproperty
    a_wait_idle: assert property (p_wait_idle) else $error("waitrequest high while idle");

    property p_ack_pulse;
        @(posedge i_core_clk) disable iff (i_rst)
        s_r.ack |=> !s_r.ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("acknowledge held too long");

    property p_wr_late;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_write && o_waitrequest && hit(i_address, TGC_OFF_CTRL)) |=> $stable(s_r.on);
    endproperty
    a_wr_late: assert property (p_wr_late) else $error("write landed before it was taken");

    // readback is a snapshot of the first access cycle
    sequence s_rd_at(logic [3:0] off);
        i_read && !s_r.ack && hit(i_address, off);
    endsequence

    property p_rd_ctrl;
        @(posedge i_core_clk) disable iff (i_rst)
        s_rd_at(TGC_OFF_CTRL) |=> (o_readdata == {31'h0, $past(s_r.on)});
    endproperty
    a_rd_ctrl: assert property (p_rd_ctrl) else $error("control readback wrong"); // RULE_07

    property p_rd_count;
        @(posedge i_core_clk) disable iff (i_rst)
        s_rd_at(TGC_OFF_COUNT) |=> (o_readdata == {16'h0000, $past(s_r.count)});
    endproperty
    a_rd_count: assert property (p_rd_count) else $error("count readback wrong"); // RULE_07

    property p_rd_gcon;
        @(posedge i_core_clk) disable iff (i_rst)
        s_rd_at(TGC_OFF_GCON) |=>
            (o_readdata[TGC_B_GE] == $past(s_r.cfg.gate_en)
            && o_readdata[TGC_B_GO] == $past(s_r.cfg.go));
    endproperty
    a_rd_gcon: assert property (p_rd_gcon) else $error("gate control readback wrong"); // RULE_06

    property p_rd_unmapped;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_read && !s_r.ack && !hit(i_address, TGC_OFF_GCON) && !hit(i_address, TGC_OFF_CTRL)
            && !hit(i_address, TGC_OFF_COUNT)) |=> (o_readdata == 32'h0000_0000);
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read nonzero"); // RULE_07

    // register writes and what may change between them
    property p_wr_on;
        @(posedge i_core_clk) disable iff (i_rst)
        wr_ctrl |=> (s_r.on == $past(i_writedata[TGC_B_ON]));
    endproperty
    a_wr_on: assert property (p_wr_on) else $error("timer on bit not written"); // RULE_08

    property p_wr_gcon;
        @(posedge i_core_clk) disable iff (i_rst)
        wr_gcon |=> (s_r.cfg.gate_en == $past(i_writedata[TGC_B_GE])
            && s_r.cfg.pol == $past(i_writedata[TGC_B_POL])
            && s_r.cfg.tgl == $past(i_writedata[TGC_B_TM])
            && s_r.cfg.spm == $past(i_writedata[TGC_B_SPM]));
    endproperty
    a_wr_gcon: assert property (p_wr_gcon) else $error("gate control not written"); // RULE_02

    property p_wr_go;
        @(posedge i_core_clk) disable iff (i_rst)
        (wr_gcon && i_writedata[TGC_B_SPM]) |=> (s_r.cfg.go == $past(i_writedata[TGC_B_GO]));
    endproperty
    a_wr_go: assert property (p_wr_go) else $error("go bit not written"); // RULE_06

    property p_wr_src;
        @(posedge i_core_clk) disable iff (i_rst)
        wr_gcon |=> (s_r.cfg.src == {$past(i_writedata[TGC_B_SS1]), $past(i_writedata[TGC_B_SS0])});
    endproperty
    a_wr_src: assert property (p_wr_src) else $error("source select not written");

    property p_cfg_hold;
        @(posedge i_core_clk) disable iff (i_rst)
        (!wr_gcon && !sp_done) |=> $stable(s_r.cfg);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("gate control changed unasked");

    property p_go_spm;
        @(posedge i_core_clk) disable iff (i_rst)
        !s_r.cfg.spm |-> !s_r.cfg.go;
    endproperty
    a_go_spm: assert property (p_go_spm) else $error("go set outside single pulse"); // RULE_05

    // counter: a write wins over a step, a step is exactly one
    property p_cnt_full;
        @(posedge i_core_clk) disable iff (i_rst)
        (wr_cnt && i_byteenable[1:0] == 2'h3) |=> (o_count == $past(i_writedata[15:0]));
    endproperty
    a_cnt_full: assert property (p_cnt_full) else $error("count write lost"); // RULE_08

    property p_cnt_lane;
        @(posedge i_core_clk) disable iff (i_rst)
        (wr_cnt && i_byteenable[1:0] == 2'h2) |=> (o_count[7:0] == $past(o_count[7:0]));
    endproperty
    a_cnt_lane: assert property (p_cnt_lane) else $error("disabled count lane changed");

    property p_gated_step;
        @(posedge i_core_clk) disable iff (i_rst)
        (s_r.on && s_r.cfg.gate_en && gate_ok && !wr_cnt) |=>
            (s_r.count == $past(s_r.count) + 16'h0001);
    endproperty
    a_gated_step: assert property (p_gated_step) else $error("open gate did not step"); // RULE_01

    property p_en_step;
        @(posedge i_core_clk) disable iff (i_rst)
        (o_count_en && !wr_cnt) |=> (o_count == $past(o_count) + 16'h0001);
    endproperty
    a_en_step: assert property (p_en_step) else $error("enable without a step"); // RULE_08

    // source select reaches the qualifier unchanged
    property p_src_pin;
        @(posedge i_core_clk) disable iff (i_rst)
        (s_r.cfg.src == 2'h0) |-> (gate_sel == pin_sync);
    endproperty
    a_src_pin: assert property (p_src_pin) else $error("pin source not selected");

    property p_src_int;
        @(posedge i_core_clk) disable iff (i_rst)
        (s_r.cfg.src == 2'h3) |-> (gate_sel == i_gate_int[2]);
    endproperty
    a_src_int: assert property (p_src_int) else $error("internal source not selected");
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import tgc_pkg::*;
    logic clk, rst, rd, wr_s, lvl, pls_s, pin, cen, wreq;
    logic [3:0] addr, len, ben;
    logic [2:0] src_in, gint;
    logic [31:0] wdat, rdat;
    logic [15:0] cnt, snap;
    int err_total, n_compared, cyc;

    tgc_timer_gate uut (.i_core_clk(clk), .i_rst(rst), .i_address(addr), .i_read(rd),
        .i_write(wr_s), .i_byteenable(ben), .i_writedata(wdat), .o_readdata(rdat),
        .o_waitrequest(wreq), .i_gate_pin(pin), .i_gate_int(gint), .o_count(cnt),
        .o_count_en(cen));
    tgc_gate_src src (.i_clk(clk), .i_rst(rst), .i_lvl(lvl), .i_pulse(pls_s),
        .i_len(len), .i_int(src_in), .o_pin(pin), .o_int(gint));

    task test_done();
        if (err_total == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    // one avalon access; entered just after a rising edge, leaves one edge after release
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        addr <= a;
        rd <= !w;
        wr_s <= w;
        wdat <= d;
        // no local limit: only the bench timeout ends a stuck access
        do begin
            @(posedge clk);
        end while (wreq !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr_s <= 1'b0;
        @(posedge clk);
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task rdc(input string n, input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(n, e, q);
    endtask
    // count steps over k edges
    task delta(input string n, input int k, input logic [15:0] e);
        logic [15:0] c0;
        c0 = cnt;
        repeat (k) @(posedge clk);
        chk(n, {16'h0, e}, {16'h0, cnt - c0});
    endtask
    // pin level change, then room for the two-stage synchroniser
    task gate(input logic l);
        lvl <= l;
        repeat (5) @(posedge clk);
    endtask
    task pls();
        pls_s <= 1'b1;
        len <= 4'h2;
        @(posedge clk);
        pls_s <= 1'b0;
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // hang guard, far above the few hundred cycles the sequence needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            err_total++;
            test_done();
        end
    end

    initial begin
        {rst, rd, wr_s, lvl, pls_s} = 5'h10;
        {addr, len, src_in, wdat} = '0;
        ben = 4'hf;
        {err_total, n_compared, cyc} = '0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdc("gcon rst", TGC_OFF_GCON, 32'h0);
        rdc("count rst", TGC_OFF_COUNT, 32'h0);
        wr(TGC_OFF_GCON, 32'hffff_fff7);
        rdc("gcon rw", TGC_OFF_GCON, 32'h0000_00f3);
        wr(4'hc, 32'hffff_ffff);
        rdc("unmapped", 4'hc, 32'h0);
        wr(TGC_OFF_COUNT, 32'hffff_fffe);
        rdc("count rw", TGC_OFF_COUNT, 32'h0000_fffe);
        // only the high lane enabled: low byte must keep its value
        ben <= 4'h2;
        wr(TGC_OFF_COUNT, 32'h0000_5600);
        ben <= 4'hf;
        rdc("count lane", TGC_OFF_COUNT, 32'h0000_56fe);
        // timer off: nothing moves even with gate active low and pin low
        wr(TGC_OFF_GCON, 32'h80);
        delta("off", 5, 16'h0);
        wr(TGC_OFF_CTRL, 32'h1);
        delta("low act", 4, 16'h4);
        gate(1'b1);
        delta("low idle", 4, 16'h0);
        wr(TGC_OFF_GCON, 32'h00);
        delta("ungated", 4, 16'h4);
        chk("count en", 32'h1, {31'h0, cen});
        wr(TGC_OFF_GCON, 32'hc0);
        delta("high act", 4, 16'h4);
        gate(1'b0);
        delta("high idle", 4, 16'h0);
        // toggle mode: each rising edge flips the qualifier
        wr(TGC_OFF_GCON, 32'he0);
        delta("tgl 0", 4, 16'h0);
        for (int i = 0; i < 3; i++) begin
            pls();
            repeat (6) @(posedge clk);
            delta("tgl", 4, (i == 1) ? 16'h0 : 16'h4);
        end
        wr(TGC_OFF_GCON, 32'hc0);
        wr(TGC_OFF_GCON, 32'he0);
        delta("tgl clr", 4, 16'h0);
        // single pulse: armed, one gate pulse counted, then done
        wr(TGC_OFF_GCON, 32'hd8);
        rdc("go set", TGC_OFF_GCON, 32'hd8);
        delta("armed", 4, 16'h0);
        snap = cnt;
        pls();
        repeat (8) @(posedge clk);
        // the first active cycle only starts the run, so a two-cycle pulse adds one
        chk("sp count", 32'h1, {16'h0, cnt - snap});
        rdc("done", TGC_OFF_GCON, 32'hd0);
        pls();
        delta("sp once", 8, 16'h0);
        // internal sources on the core clock
        for (int s = 1; s < 4; s++) begin
            wr(TGC_OFF_GCON, 32'hc0 | s);
            src_in <= 3'h1 << (s - 1);
            repeat (3) @(posedge clk);
            delta("src on", 4, 16'h4);
            src_in <= ~(3'h1 << (s - 1));
            repeat (3) @(posedge clk);
            delta("src off", 4, 16'h0);
        end
        test_done();
    end
endmodule
`default_nettype wire

/* testbench/tgc_gate_src.sv */
`default_nettype none
module tgc_gate_src (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // bench commands
    input wire logic i_lvl,
    input wire logic i_pulse,
    input wire logic [3:0] i_len,
    input wire logic [2:0] i_int,
    // gate sources seen by the timer
    output logic o_pin,
    output logic [2:0] o_int
);
    logic [3:0] left_r;
    // pin rests at the commanded level; a pulse overrides it for i_len cycles
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            left_r <= 4'h0;
            o_pin <= 1'b0;
            o_int <= 3'h0;
        end else begin
            o_int <= i_int;
            if (i_pulse) begin
                left_r <= i_len;
                o_pin <= 1'b1;
            end else if (left_r > 4'h1) begin
                left_r <= left_r - 4'h1;
            end else begin
                left_r <= 4'h0;
                o_pin <= i_lvl;
            end
        end
    end
endmodule
`default_nettype wire
